// ===== design/power_stage_controller.v
// Three-module power stage PWM generator, top level.
// Assumes one 10 MHz clock, synchronous reset and stage sources as enable pulses.
`include "pwm_stage_map.vh"

module power_stage_controller (
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst,
    // Processor byte port to the compare registers.
    input  wire [4:0]  cpu_addr,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    input  wire [7:0]  cpu_wdata,
    output wire [7:0]  cpu_rdata,
    // Stage clock sources as one-cycle enables on mclk.
    input  wire        pll_tick,
    input  wire        io_tick,
    input  wire [2:0]  stage_clock_select,
    // Run control and configuration.
    input  wire        run_req,
    input  wire        complete_cycle_stop,
    input  wire        update_hold,
    input  wire        centered_mode,
    input  wire [2:0]  overlap_protect_enable,
    input  wire [2:0]  polarity_a_high,
    input  wire [2:0]  polarity_b_high,
    // Emergency inputs, one per module, active high.
    input  wire [2:0]  fault_in,
    // Waveform outputs.
    output wire [2:0]  module_output_a,
    output wire [2:0]  module_output_b,
    output wire [2:0]  adc_sync,
    // Status.
    output wire        running,
    output wire        cycle_end_pulse,
    output wire [11:0] counter_value,
    output wire [2:0]  fault_active
);

    // Run states.
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_DRAIN = 2'h2;

    // Byte port state.
    reg  [7:0]   hold_q;
    reg  [7:0]   rdata_q;
    reg  [15:0]  shadow_q [0:9];
    wire [159:0] shadow_flat;
    wire [3:0]   acc_idx;
    wire         acc_hi;
    wire         acc_hit;

    // Active timing set, loaded at cycle boundaries or while stopped.
    reg  [159:0] act_q;
    reg          centered_q;
    reg  [2:0]   ovl_q;
    reg  [2:0]   pol_a_q;
    reg  [2:0]   pol_b_q;

    // Counter and run control.
    reg  [1:0]   state_q;
    reg  [1:0]   state_d;
    reg  [11:0]  cnt_q;
    reg  [11:0]  cnt_d;
    reg          up_q;
    reg          up_d;
    reg          cycle_end_q;
    wire [2:0]   stage_tick;
    wire         cnt_tick;
    wire [11:0]  top_act;
    wire [11:0]  top_shadow;
    wire [11:0]  top_next;
    wire         centered_next;
    wire         at_end;
    wire         end_now;
    wire         load_now;
    wire         run_w;

    // Address split for the byte port.
    assign acc_idx = cpu_addr[4:1];
    assign acc_hi  = cpu_addr[`ADDR_HI_BIT];
    assign acc_hit = (acc_idx < `REG_COUNT);

    // Processor accesses through the shared high-byte latch.
    always @(posedge mclk) begin : byte_port
        integer i;
        if (rst) begin
            hold_q  <= `HOLD_RST;
            rdata_q <= 8'h00;
            for (i = 0; i < 10; i = i + 1) begin
                shadow_q[i] <= `CMP_RST;
            end
        end else begin
            if (cpu_wr && acc_hi) begin
                hold_q <= cpu_wdata;
            end
            if (cpu_wr && !acc_hi && acc_hit) begin
                shadow_q[acc_idx] <= {hold_q, cpu_wdata};
            end
            if (cpu_rd) begin
                if (acc_hi) begin
                    rdata_q <= hold_q;
                end else if (acc_hit) begin
                    rdata_q <= shadow_q[acc_idx][7:0];
                    hold_q  <= shadow_q[acc_idx][15:8];
                end else begin
                    rdata_q <= 8'h00;
                end
            end
        end
    end

    // Flatten the written registers and pick each module's stage source.
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_flat
            assign shadow_flat[g*16 +: 16] = shadow_q[g];
        end
        for (g = 0; g < 3; g = g + 1) begin : g_tick
            assign stage_tick[g] = stage_clock_select[g] ? pll_tick : io_tick;
        end
    endgenerate

    // The shared counter steps on module zero's stage source.
    assign cnt_tick   = stage_tick[0];
    assign top_act    = act_q[`IDX_TOP*16 +: 12];
    assign top_shadow = shadow_flat[`IDX_TOP*16 +: 12];
    assign run_w      = (state_q != ST_IDLE);

    // The cycle ends after sub-cycle B: at the top, and in centered mode on the way up.
    assign at_end  = centered_q ? (up_q && (cnt_q == top_act)) : (cnt_q == top_act);
    assign end_now = run_w && cnt_tick && at_end;

    // Values transfer at cycle end, or freely while stopped, unless held.
    assign load_now      = !update_hold && (!run_w || end_now);
    assign top_next      = load_now ? top_shadow : top_act;
    assign centered_next = load_now ? centered_mode : centered_q;

    // Transfer of compares and output configuration to the active set.
    always @(posedge mclk) begin
        if (rst) begin
            act_q      <= {`REG_COUNT{`CMP_RST}};
            centered_q <= 1'b0;
            ovl_q      <= `OVL_RST;
            pol_a_q    <= `POL_RST;
            pol_b_q    <= `POL_RST;
        end else if (load_now) begin
            act_q      <= shadow_flat;
            centered_q <= centered_mode;
            ovl_q      <= overlap_protect_enable;
            pol_a_q    <= polarity_a_high;
            pol_b_q    <= polarity_b_high;
        end
    end

    // Run state machine and counter next values.
    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        up_d    = up_q;
        case (state_q)
            ST_IDLE: begin
                // Park at the starting point of the next cycle.
                cnt_d = centered_next ? top_next : `CNT_RST;
                up_d  = !centered_next;
                if (run_req) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN, ST_DRAIN: begin
                if (!run_req && !complete_cycle_stop) begin
                    state_d = ST_IDLE;
                end else if (complete_cycle_stop) begin
                    state_d = run_req ? ST_RUN : ST_DRAIN;
                end else begin
                    state_d = ST_RUN;
                end
                if (cnt_tick) begin
                    if (at_end) begin
                        // A new cycle starts from the freshly loaded top and mode.
                        cnt_d = centered_next ? top_next : `CNT_RST;
                        up_d  = !centered_next;
                        if (complete_cycle_stop && !run_req) begin
                            state_d = ST_IDLE;
                        end
                    end else if (!centered_q) begin
                        cnt_d = cnt_q + 12'h001;
                    end else if (!up_q) begin
                        // Zero is seen twice so the cycle spans 2*(top+1) ticks.
                        if (cnt_q == `CNT_RST) begin
                            up_d = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 12'h001;
                        end
                    end else begin
                        cnt_d = cnt_q + 12'h001;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Counter, direction and run state registers.
    always @(posedge mclk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            cnt_q       <= `CNT_RST;
            up_q        <= 1'b1;
            cycle_end_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            up_q        <= up_d;
            cycle_end_q <= end_now;
        end
    end

    // The three modules, each with its own compares and emergency input.
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_mod
            stage_channel u_chan (
                .mclk         (mclk),
                .rst          (rst),
                .tick         (stage_tick[g]),
                .running      (run_w),
                .centered     (centered_q),
                .cnt          (cnt_q),
                .set_a        (act_q[(g*`IDX_STRIDE+`IDX_SA)*16 +: 12]),
                .reset_a      (act_q[(g*`IDX_STRIDE+`IDX_RA)*16 +: 12]),
                .set_b        (act_q[(g*`IDX_STRIDE+`IDX_SB)*16 +: 12]),
                .overlap_en   (ovl_q[g]),
                .pol_a        (pol_a_q[g]),
                .pol_b        (pol_b_q[g]),
                .fault_pin    (fault_in[g]),
                .out_a_q      (module_output_a[g]),
                .out_b_q      (module_output_b[g]),
                .adc_sync_q   (adc_sync[g]),
                .fault_active (fault_active[g])
            );
        end
    endgenerate

    // Status outputs, all from registers.
    assign cpu_rdata       = rdata_q;
    assign running         = run_w;
    assign cycle_end_pulse = cycle_end_q;
    assign counter_value   = cnt_q;

endmodule

// ===== design/stage_channel.v
// One PWM module: part A and part B generators with polarity and protection.
// Assumes the shared counter and active compares come from the top level.
`include "pwm_stage_map.vh"

module stage_channel (
    // Clock, reset and this module's stage tick.
    input  wire        mclk,
    input  wire        rst,
    input  wire        tick,
    // Shared timing state.
    input  wire        running,
    input  wire        centered,
    input  wire [11:0] cnt,
    // Active compares and configuration.
    input  wire [11:0] set_a,
    input  wire [11:0] reset_a,
    input  wire [11:0] set_b,
    input  wire        overlap_en,
    input  wire        pol_a,
    input  wire        pol_b,
    input  wire        fault_pin,
    // Outputs.
    output reg         out_a_q,
    output reg         out_b_q,
    output reg         adc_sync_q,
    output wire        fault_active
);

    wire act_a;
    wire act_b;
    wire clash;
    wire en_a;
    wire en_b;

    stage_fault_sync u_fault (
        .mclk      (mclk),
        .rst       (rst),
        .fault_pin (fault_pin),
        .fault_q   (fault_active)
    );

    // Compare decode; centered mode is symmetric around count zero.
    assign act_a = centered ? (cnt < set_a)
                            : ((cnt > set_a) && (cnt <= reset_a));
    assign act_b = centered ? (cnt >= set_b)
                            : (cnt > set_b);
    // Both outputs are dropped when they would overlap under protection.
    assign clash = overlap_en && act_a && act_b;
    assign en_a  = running && !fault_active && act_a && !clash;
    assign en_b  = running && !fault_active && act_b && !clash;

    // Outputs follow the compares on this module's tick; stop or fault acts at once.
    always @(posedge mclk) begin
        if (rst) begin
            out_a_q    <= 1'b0;
            out_b_q    <= 1'b0;
            adc_sync_q <= 1'b0;
        end else begin
            if (tick || !running || fault_active) begin
                out_a_q <= pol_a ? en_a : !en_a;
                out_b_q <= pol_b ? en_b : !en_b;
            end
            adc_sync_q <= tick && running && (cnt == reset_a);
        end
    end

endmodule

// ===== design/stage_fault_sync.v
// Emergency input synchroniser for one module.
// Assumes an asynchronous pin; a change counts once two later stages agree.
`include "pwm_stage_map.vh"

module stage_fault_sync (
    // Clock and reset.
    input  wire mclk,
    input  wire rst,
    // Pin and filtered level.
    input  wire fault_pin,
    output reg  fault_q
);

    reg [2:0] sync_q;

    // Three-stage shift; only stage one reads stage zero.
    always @(posedge mclk) begin
        if (rst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], fault_pin};
        end
    end

    // Accept a new level only when stages one and two agree.
    always @(posedge mclk) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            fault_q <= sync_q[2];
        end
    end

endmodule

// ===== shared/pwm_stage_map.vh
// Constants for the three-module power stage PWM generator.
// Holds macros only; included by bare name from every design file.
//
// Overview of operation
// - One 8-bit holding latch stores the high byte for all 16-bit registers.
// - A low-byte write loads latch plus written byte into the register at once.
// - A low-byte read copies that register's high byte into the latch.
// - One free-running 12-bit counter runs to the top compare, then down or wraps.
// - Three modules, each with part A and part B generators, six outputs.
// - A cycle is sub-cycle A then sub-cycle B; it ends after B.
// - New settings apply at the end of a complete cycle, or at once while stopped.
// - One mode bit selects one-ramp or centered for all generators.
// - Centered mode counts down then up, halving PWM frequency.
// - One-ramp mode gives edge-aligned outputs at twice centered frequency.
// - One-ramp A active time is reset A minus set A.
// - One-ramp B dead time is set B minus reset A; active is top minus set B.
// - One-ramp dead time before A is set A plus one stage clock.
// - Without overlap protection, one-ramp A and B may overlap.
// - Centered on-times are 2*setA and 2*(top-setB+1); dead is setB-setA.
// - Centered cycle lasts 2*(top+1) stage clocks, at least two.
// - Centered outputs are symmetric about the middle of the period.
// - Centered mode ignores reset A for outputs; it times the converter sync.
// - Each output polarity is selectable without changing its timing.
// - Each module has its own emergency input that shuts its outputs fast.
// - While update hold is set no new values transfer; else at cycle end or while stopped.
// - Overlap protection stops both outputs of a module being active together.
// - A per-module select picks the stage clock from PLL or I/O source.
`ifndef PWM_STAGE_MAP_VH
`define PWM_STAGE_MAP_VH

// Register indices; the byte address is {index, high_byte}.
`define IDX_SA      4'h0
`define IDX_RA      4'h1
`define IDX_SB      4'h2
`define IDX_STRIDE  3
`define IDX_TOP     4'h9
`define REG_COUNT   4'ha
`define ADDR_HI_BIT 0

// Reset values.
`define CMP_RST     16'h0000
`define HOLD_RST    8'h00
`define CNT_RST     12'h000
`define POL_RST     3'h7
`define OVL_RST     3'h7

`endif

// ===== verification/half_bridge_model.sv
// Model of three external half-bridges fed by the six outputs.
// Assumes a switch conducts while its output sits at the active level.
module half_bridge_model (
    // Clock.
    input wire logic       mclk,
    // Gate drives and their polarity.
    input wire logic [2:0] module_output_a,
    input wire logic [2:0] module_output_b,
    input wire logic [2:0] polarity_a_high,
    input wire logic [2:0] polarity_b_high,
    // Cycles in which some leg conducted through both switches.
    output int             shoot_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [2:0] on_a = ~(module_output_a ^ polarity_a_high);
    wire [2:0] on_b = ~(module_output_b ^ polarity_b_high);
    initial shoot_cnt = 0;

    // Counts cross conduction, which a real bridge would not survive.
    always @(posedge mclk) begin
        if ((on_a & on_b) != 3'h0)
            shoot_cnt <= shoot_cnt + 1;
    end
endmodule

// ===== verification/stage_checker.sv
// Port-level assertions for the three-module PWM stage.
// Assumes io_tick held high and module 0 stepping the shared counter.
module stage_checker (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        rst,
    // Byte port and tick sources.
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        io_tick,
    input wire logic [2:0]  stage_clock_select,
    // Configuration.
    input wire logic        update_hold,
    input wire logic        centered_mode,
    input wire logic [2:0]  overlap_protect_enable,
    input wire logic [2:0]  polarity_a_high,
    input wire logic [2:0]  polarity_b_high,
    input wire logic [2:0]  fault_in,
    // Outputs and status.
    input wire logic [2:0]  module_output_a,
    input wire logic [2:0]  module_output_b,
    input wire logic [2:0]  adc_sync,
    input wire logic        running,
    input wire logic        cycle_end_pulse,
    input wire logic [11:0] counter_value,
    input wire logic [2:0]  fault_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] cfg_q;
    logic [5:0]  quiet_q;
    wire  [10:0] cfg_d = {update_hold, centered_mode, overlap_protect_enable,
                          polarity_a_high, polarity_b_high};
    wire         settled = (quiet_q == 6'h3f);

    // Counts quiet cycles, so checks wait until a new setting has surely moved in.
    always @(posedge mclk) begin
        cfg_q <= cfg_d;
        if (rst || cfg_d != cfg_q)
            quiet_q <= 6'h00;
        else if (!settled)
            quiet_q <= quiet_q + 6'h01;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        counter_value == 12'h000 && module_output_a == 3'h0 && module_output_b == 3'h0 && !running)
        else $error("reset left state behind");
    idle_park_a: assert property (!running && $past(!running) && !$past(update_hold)
        && !$past(centered_mode) |-> counter_value == 12'h000)
        else $error("counter moved while idle");
    count_step_a: assert property (running && $past(running) && settled && !centered_mode
        && $past(io_tick) && !stage_clock_select[0] |-> counter_value != $past(counter_value))
        else $error("counter missed a tick");
    no_overlap_a: assert property (settled && overlap_protect_enable[0]
        && polarity_a_high[0] && polarity_b_high[0] |-> !(module_output_a[0] && module_output_b[0]))
        else $error("both outputs active");
    fault_rise_a: assert property ($rose(fault_in[0]) && !fault_active[0] |-> ##[2:4] fault_active[0])
        else $error("fault not seen in time");
    fault_off_a: assert property (fault_active[0] && settled |=>
        module_output_a[0] != polarity_a_high[0] && module_output_b[0] != polarity_b_high[0])
        else $error("outputs active under fault");
    idle_out_a: assert property (!running && $past(!running) && settled |->
        (module_output_a ^ polarity_a_high) == 3'h7)
        else $error("output active while idle");
    end_pulse_a: assert property (cycle_end_pulse |=> !cycle_end_pulse)
        else $error("cycle end longer than one cycle");
    adc_pulse_a: assert property (adc_sync[0] |=> !adc_sync[0])
        else $error("converter sync too long");
    rdata_hold_a: assert property (!$past(cpu_rd) |-> $stable(cpu_rdata))
        else $error("read data changed without read");
endmodule

bind power_stage_controller stage_checker chk (.mclk, .rst, .cpu_rd, .cpu_rdata, .io_tick,
    .stage_clock_select, .update_hold, .centered_mode, .overlap_protect_enable,
    .polarity_a_high, .polarity_b_high, .fault_in, .module_output_a, .module_output_b,
    .adc_sync, .running, .cycle_end_pulse, .counter_value, .fault_active);

// ===== verification/tb_top.sv
// Self-checking bench for the three-module PWM stage.
// Assumes io_tick always high, so module 0 steps the counter every mclk.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, pll_tick = 0, io_tick = 1;
    logic        run_req = 0, complete_cycle_stop = 0, update_hold = 0, centered_mode = 0;
    logic [4:0]  cpu_addr = 5'h00;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [2:0]  stage_clock_select = 3'h2, overlap_protect_enable = 3'h7, fault_in = 3'h0;
    logic [2:0]  polarity_a_high = 3'h7, polarity_b_high = 3'h7;
    wire  [7:0]  cpu_rdata;
    wire  [2:0]  module_output_a, module_output_b, adc_sync, fault_active;
    wire         running, cycle_end_pulse;
    wire  [11:0] counter_value;
    logic [15:0] rv, ta, tb, per, ad;
    int          fails = 0, check_count = 0, cycles = 0, shoot_cnt, s0, i;

    power_stage_controller uut (.mclk, .rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
        .cpu_rdata, .pll_tick, .io_tick, .stage_clock_select, .run_req, .complete_cycle_stop,
        .update_hold, .centered_mode, .overlap_protect_enable, .polarity_a_high,
        .polarity_b_high, .fault_in, .module_output_a, .module_output_b, .adc_sync,
        .running, .cycle_end_pulse, .counter_value, .fault_active);
    half_bridge_model hb (.mclk, .module_output_a, .module_output_b, .polarity_a_high,
        .polarity_b_high, .shoot_cnt);

    // Clock, a second tick source for module 1, and the hang limit.
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) begin
        pll_tick <= ~pll_tick;
        cycles++;
        if (cycles == 4000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Writes high byte then low byte, strobe held across the pair.
    task automatic wr16(input logic [3:0] idx, input logic [15:0] v);
        cpu_addr <= {idx, 1'b1};
        cpu_wdata <= v[15:8];
        cpu_wr <= 1;
        @(posedge mclk);
        cpu_addr <= {idx, 1'b0};
        cpu_wdata <= v[7:0];
        @(posedge mclk);
        cpu_wr <= 0;
        @(posedge mclk);
    endtask

    // Reads the low byte of one index, then the shared latch through another index's high-byte address.
    task automatic rdp(input logic [3:0] lo, input logic [3:0] hi);
        cpu_addr <= {lo, 1'b0};
        cpu_rd <= 1;
        @(posedge mclk);
        cpu_addr <= {hi, 1'b1};
        #1 rv[7:0] = cpu_rdata;
        @(posedge mclk);
        cpu_rd <= 0;
        #1 rv[15:8] = cpu_rdata;
        @(posedge mclk);
    endtask

    // Measures one whole cycle of module 0 between two cycle-end pulses.
    task automatic meas;
        ta = 0;
        ad = 0;
        tb = 0;
        per = 0;
        i = 0;
        do begin
            @(posedge mclk);
            #1 i++;
        end while (cycle_end_pulse !== 1'b1 && i < 60);
        do begin
            @(posedge mclk);
            #1 per++;
            ta += 16'(module_output_a[0]);
            tb += 16'(module_output_b[0]);
            ad += 16'(adc_sync[0]);
        end while (cycle_end_pulse !== 1'b1 && per < 60);
        @(posedge mclk);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        #1 chk(16'(counter_value), 16'h0000);
        chk(16'({module_output_a, module_output_b}), 16'h0000);
        repeat (70) @(posedge mclk);
        rdp(0, 0);
        chk(rv, 16'h0000);
        wr16(3, 16'h0a5c);
        rdp(3, 3);
        chk(rv, 16'h0a5c);
        rdp(3, 0);
        chk(rv, 16'h0a5c);
        rdp(10, 0);
        chk(rv, 16'h0a00);
        wr16(0, 16'h0002);
        wr16(1, 16'h0005);
        wr16(2, 16'h0007);
        wr16(9, 16'h0009);
        run_req <= 1;
        meas();
        chk(per, 16'h000a);
        chk(ta, 16'h0003);
        chk(tb, 16'h0002);
        chk(per - ta - tb, 16'h0005);
        update_hold <= 1;
        wr16(0, 16'h0004);
        meas();
        chk(ta, 16'h0003);
        update_hold <= 0;
        meas();
        chk(ta, 16'h0001);
        wr16(0, 16'h0002);
        wr16(1, 16'h0008);
        wr16(2, 16'h0005);
        overlap_protect_enable <= 3'h6;
        s0 = shoot_cnt;
        meas();
        chk(ta, 16'h0006);
        chk(tb, 16'h0004);
        chk(16'(shoot_cnt - s0), 16'h0003);
        overlap_protect_enable <= 3'h7;
        meas();
        s0 = shoot_cnt;
        meas();
        chk(16'(shoot_cnt - s0), 16'h0000);
        wr16(1, 16'h0005);
        wr16(2, 16'h0007);
        polarity_a_high <= 3'h6;
        meas();
        chk(ta, 16'h0007);
        polarity_a_high <= 3'h7;
        centered_mode <= 1;
        meas();
        meas();
        chk(per, 16'h0014);
        chk(ta, 16'h0004);
        chk(tb, 16'h0006);
        chk(ad, 16'h0002);
        centered_mode <= 0;
        meas();
        complete_cycle_stop <= 1;
        meas();
        run_req <= 0;
        repeat (3) @(posedge mclk);
        #1 chk(16'(running), 16'h0001);
        for (i = 0; i < 12 && running !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        #1 chk(16'(running), 16'h0000);
        @(posedge mclk);
        complete_cycle_stop <= 0;
        run_req <= 1;
        fault_in <= 3'h1;
        repeat (8) @(posedge mclk);
        #1 chk(16'(fault_active), 16'h0001);
        meas();
        chk(ta + tb, 16'h0000);
        fault_in <= 3'h0;
        rst <= 1;
        repeat (2) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        #1 chk(16'({counter_value, module_output_a[0]}), 16'h0000);
        conclude();
    end
endmodule
